// ---- include/phy_mode_pkg.sv ----
// Constants and carrier types for the vendor mode control register bank.
// Assumes a single 50 MHz clock domain and a plain register port.
package phy_mode_pkg;
	localparam int          ADDR_W          = 5;
	localparam int          DATA_W          = 16;
	localparam logic [4:0]  VMC_ADDR        = 5'h10;
	localparam logic [15:0] VMC_RESET       = 16'h0140;
	localparam logic [15:0] VMC_FIXED_MASK  = 16'h23CC;
	localparam logic [15:0] VMC_FIXED_VALUE = 16'h0140;
	localparam int          BIT_REPEATER    = 15;
	localparam int          BIT_IRQ_POL     = 14;
	localparam int          BIT_TX_HIZ      = 12;
	localparam int          BIT_HEARTBEAT   = 11;
	localparam int          BIT_NAT_LOOP    = 10;
	localparam int          BIT_AUTO_POLARITY_DISABLE_DIS    = 5;
	localparam int          BIT_RX_POL      = 4;
	localparam int          BIT_BYPASS      = 1;
	localparam int          BIT_RX_GATE     = 0;

	typedef struct packed {
		logic repeater_select;
		logic irq_polarity_sel;
		logic tx_hiz_select;
		logic heartbeat_test_inhibit;
		logic natural_loop_10m;
		logic auto_polarity_disable;
		logic rx_polarity_force;
		logic coding_bypass;
		logic rx_clock_gating;
	} mode_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;
endpackage : phy_mode_pkg

// ---- src/phy_vendor_mode_control.sv ----
// Vendor mode control register of the PHY and the controls it drives.
// Assumes register strobes and PHY status inputs synchronous to sys_clk.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module phy_vendor_mode_control
	import phy_mode_pkg::*;
(
	input  wire logic                           sys_clk,
	input  wire logic                           rstn,
	input  wire logic [phy_mode_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [phy_mode_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [phy_mode_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                           mode_10m,
	input  wire logic                           mode_100tx,
	input  wire logic                           rx_pol_reversed,
	input  wire logic                           rx_active,
	input  wire logic                           loopback_control,
	input  wire logic                           phy_event,
	output logic                                phy_irq,
	output logic                                rx_invert,
	output logic                                pcs_bypass_en,
	output logic                                rx_clk_en,
	output logic                                repeater_select,
	output logic                                tx_hiz_select,
	output logic                                heartbeat_test_inhibit,
	output logic                                natural_loop_10m
);
	import phy_mode_pkg::*;

	mode_ctrl_t        ctrl_q, ctrl_d;
	logic              auto_inv_q, auto_inv_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic              irq_q, irq_d;
	logic              inv_q, inv_d;
	logic              byp_q, byp_d;
	logic              clk_en_q, clk_en_d;
	logic [DATA_W-1:0] reg_value;
	logic              wr_hit;
	logic              rd_hit;

	// Assemble the readable word; fixed fields come from constants only
	function automatic logic [DATA_W-1:0] pack_word(mode_ctrl_t c,
			logic auto_inv);
		logic [DATA_W-1:0] w;
		w = VMC_FIXED_VALUE;
		w[BIT_REPEATER]  = c.repeater_select;
		w[BIT_IRQ_POL]   = c.irq_polarity_sel;
		w[BIT_TX_HIZ]    = c.tx_hiz_select;
		w[BIT_HEARTBEAT] = c.heartbeat_test_inhibit;
		w[BIT_NAT_LOOP]  = c.natural_loop_10m;
		w[BIT_AUTO_POLARITY_DISABLE_DIS]  = c.auto_polarity_disable;
		// Status view while automatic, forced value otherwise
		w[BIT_RX_POL]    = c.auto_polarity_disable ? c.rx_polarity_force
			: auto_inv;
		w[BIT_BYPASS]    = c.coding_bypass;
		w[BIT_RX_GATE]   = c.rx_clock_gating;
		return w;
	endfunction : pack_word

	// Only one word is mapped; every other address reads zero
	function automatic logic is_mapped(logic [ADDR_W-1:0] a);
		return a == VMC_ADDR;
	endfunction : is_mapped

	// Strobes qualified by the decode; other addresses are ignored
	assign wr_hit    = reg_wr & is_mapped(reg_addr);
	assign rd_hit    = reg_rd & is_mapped(reg_addr);
	assign reg_value = pack_word(ctrl_q, auto_inv_q);

	// Only read-write fields are stored; reserved ones are constants
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_hit) begin
			ctrl_d.repeater_select        = reg_wdata[BIT_REPEATER];
			ctrl_d.irq_polarity_sel       = reg_wdata[BIT_IRQ_POL];
			ctrl_d.tx_hiz_select          = reg_wdata[BIT_TX_HIZ];
			ctrl_d.heartbeat_test_inhibit = reg_wdata[BIT_HEARTBEAT];
			ctrl_d.natural_loop_10m       = reg_wdata[BIT_NAT_LOOP];
			ctrl_d.auto_polarity_disable  = reg_wdata[BIT_AUTO_POLARITY_DISABLE_DIS];
			// Bit 4 only takes a write while forcing is allowed
			if (ctrl_q.auto_polarity_disable) begin
				ctrl_d.rx_polarity_force = reg_wdata[BIT_RX_POL];
			end
			ctrl_d.coding_bypass          = reg_wdata[BIT_BYPASS];
			ctrl_d.rx_clock_gating        = reg_wdata[BIT_RX_GATE];
		end
	end

	always_comb begin
		// Correction only tracks the pair in 10BASE-T; cleared while auto-polarity is disabled, held otherwise
		auto_inv_d = auto_inv_q;
		if (ctrl_q.auto_polarity_disable) begin
			auto_inv_d = 1'b0;
		end else if (mode_10m) begin
			auto_inv_d = rx_pol_reversed;
		end
	end

	// Reset loads the documented word field by field
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q.repeater_select        <= VMC_RESET[BIT_REPEATER];
			ctrl_q.irq_polarity_sel       <= VMC_RESET[BIT_IRQ_POL];
			ctrl_q.tx_hiz_select          <= VMC_RESET[BIT_TX_HIZ];
			ctrl_q.heartbeat_test_inhibit <= VMC_RESET[BIT_HEARTBEAT];
			ctrl_q.natural_loop_10m       <= VMC_RESET[BIT_NAT_LOOP];
			ctrl_q.auto_polarity_disable  <= VMC_RESET[BIT_AUTO_POLARITY_DISABLE_DIS];
			ctrl_q.rx_polarity_force      <= VMC_RESET[BIT_RX_POL];
			ctrl_q.coding_bypass          <= VMC_RESET[BIT_BYPASS];
			ctrl_q.rx_clock_gating        <= VMC_RESET[BIT_RX_GATE];
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			auto_inv_q <= 1'b0;
		end else begin
			auto_inv_q <= auto_inv_d;
		end
	end

	// Every derived control is registered: one cycle of lag buys clean pins
	// Read data stands for one cycle only and is zero otherwise
	always_comb begin
		rdata_d = '0;
		if (rd_hit) begin
			rdata_d = reg_value;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Idle event with low polarity gives a high pin out of reset
	always_comb begin
		irq_d = ctrl_q.irq_polarity_sel ? phy_event : ~phy_event;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 1'b1;
		end else begin
			irq_q <= irq_d;
		end
	end

	// Forced value wins whenever auto-polarity is disabled
	always_comb begin
		inv_d = ctrl_q.auto_polarity_disable ? ctrl_q.rx_polarity_force
			: auto_inv_q;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			inv_q <= 1'b0;
		end else begin
			inv_q <= inv_d;
		end
	end

	// Bypass only acts in 100BASE-TX; other modes ignore the bit
	always_comb begin
		byp_d = ctrl_q.coding_bypass & mode_100tx;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			byp_q <= 1'b0;
		end else begin
			byp_q <= byp_d;
		end
	end

	// Gating is only honoured in 100BASE-TX and never in loopback
	always_comb begin
		clk_en_d = ~(ctrl_q.rx_clock_gating & mode_100tx & ~rx_active
			& ~loopback_control);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			clk_en_q <= 1'b1;
		end else begin
			clk_en_q <= clk_en_d;
		end
	end

	// Remaining mode bits drive the PHY straight from their flops
	assign reg_rdata              = rdata_q;
	assign phy_irq                = irq_q;
	assign rx_invert              = inv_q;
	assign pcs_bypass_en          = byp_q;
	assign rx_clk_en              = clk_en_q;
	assign repeater_select        = ctrl_q.repeater_select;
	assign tx_hiz_select          = ctrl_q.tx_hiz_select;
	assign heartbeat_test_inhibit = ctrl_q.heartbeat_test_inhibit;
	assign natural_loop_10m       = ctrl_q.natural_loop_10m;
endmodule : phy_vendor_mode_control
`default_nettype wire

// ---- verification/phy_vendor_mode_control_sva.sv ----
// Assertions on the vendor mode control register port and derived controls.
// Assumes one-cycle strobes and read data in the cycle after the read.
`timescale 1ns/1ps
`default_nettype none
module vmc_sva
	import phy_mode_pkg::*;
(
	input wire logic	sys_clk,
	input wire logic	rstn,
	input wire logic [phy_mode_pkg::ADDR_W-1:0]	reg_addr,
	input wire logic [phy_mode_pkg::DATA_W-1:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [phy_mode_pkg::DATA_W-1:0]	reg_rdata,
	input wire logic	mode_10m,
	input wire logic	mode_100tx,
	input wire logic	rx_active,
	input wire logic	loopback_control,
	input wire logic	phy_event,
	input wire logic	phy_irq,
	input wire logic	pcs_bypass_en,
	input wire logic	rx_clk_en
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence rd_s; reg_rd && reg_addr == VMC_ADDR; endsequence
	sequence wr_s; reg_wr && reg_addr == VMC_ADDR; endsequence
	chk_read_unmapped: assert property (reg_rd && reg_addr != VMC_ADDR |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_read_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	chk_fixed_bits: assert property (rd_s |=> (reg_rdata & VMC_FIXED_MASK) == VMC_FIXED_VALUE)
		else $error("fixed bits wrong");
	chk_irq_polarity: assert property (rd_s |=> phy_irq == ($past(phy_event) ~^ reg_rdata[14]))
		else $error("irq polarity wrong");
	chk_bypass_out: assert property (rd_s |=> pcs_bypass_en == (reg_rdata[1] & $past(mode_100tx)))
		else $error("bypass output wrong");
	chk_gate_out: assert property (rd_s |=> rx_clk_en == !(reg_rdata[0] && $past(mode_100tx) && !$past(rx_active) && !$past(loopback_control)))
		else $error("clock gating wrong");
	chk_pol_forced: assert property (
		rd_s ##1 (wr_s and (reg_rdata[5] && reg_wdata[5:4] == 2'b11))
		##1 rd_s |=> reg_rdata[5:4] == 2'b11)
		else $error("forced polarity lost");
	chk_pol_status: assert property (
		(rd_s and !mode_10m)
		##1 (wr_s and (!reg_rdata[5] && !reg_wdata[5] && !mode_10m))
		##1 rd_s |=> reg_rdata[4] == $past(reg_rdata[4], 2))
		else $error("status bit written");
endmodule : vmc_sva
bind phy_vendor_mode_control vmc_sva u_sva (.sys_clk, .rstn, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .mode_10m, .mode_100tx, .rx_active,
	.loopback_control, .phy_event, .phy_irq, .pcs_bypass_en, .rx_clk_en);
`default_nettype wire

// ---- verification/phy_vendor_mode_control_test.sv ----
// Bench for the vendor mode control register bank.
// Drives every port itself; no far-side model.
`timescale 1ns/1ps
`default_nettype none
module phy_vendor_mode_control_test;
	logic	sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, phy_event = 0;
	logic	mode_10m = 0, mode_100tx = 0, rx_pol_reversed = 0, rx_active = 0;
	logic	loopback_control = 0, phy_irq, rx_invert, pcs_bypass_en, rx_clk_en;
	logic	repeater_select, tx_hiz_select;
	logic	heartbeat_test_inhibit, natural_loop_10m;
	logic [3:0]	mode_bits;
	logic [4:0]	reg_addr = 0;
	logic [15:0]	reg_wdata = 0, reg_rdata;
	int	mismatches = 0, n_checks = 0;
	always #10 sys_clk = ~sys_clk;
	phy_vendor_mode_control u_dut (.sys_clk, .rstn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .mode_10m, .mode_100tx, .rx_pol_reversed,
		.rx_active, .loopback_control, .phy_event, .phy_irq, .rx_invert,
		.pcs_bypass_en, .rx_clk_en, .repeater_select, .tx_hiz_select,
		.heartbeat_test_inhibit, .natural_loop_10m);
	assign mode_bits = {repeater_select, tx_hiz_select,
		heartbeat_test_inhibit, natural_loop_10m};
	task check(input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task end_sim;
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task op(input logic w, r, input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask : op
	task rd(input logic [4:0] a, input logic [15:0] exp);
		op(0, 1, a, 16'h0000);
		op(0, 0, a, 16'h0000);
		#1 check(reg_rdata, exp);
	endtask : rd
	// Read, write, read with no gap so the bit 4 rules see the old bit 5
	task rwr(input logic [15:0] d, exp);
		op(0, 1, 5'h10, 16'h0000);
		op(1, 0, 5'h10, d);
		rd(5'h10, exp);
	endtask : rwr
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1;
		rd(5'h10, 16'h0140);
		rd(5'h11, 16'h0000);
		op(1, 0, 5'h03, 16'hFFFF);
		rwr(16'hFFDC, 16'hDD40);
		check(16'(phy_irq), 16'h0000);
		check(16'(mode_bits), 16'h000F);
		rwr(16'hFFFC, 16'hDD60);
		rwr(16'hFFFC, 16'hDD70);
		check(16'(rx_invert), 16'h0001);
		@(posedge sys_clk) mode_100tx <= 1;
		rwr(16'hDD71, 16'hDD71);
		check(16'(rx_clk_en), 16'h0000);
		check(16'(pcs_bypass_en), 16'h0000);
		@(posedge sys_clk) loopback_control <= 1;
		repeat (2) @(posedge sys_clk);
		#1 check(16'(rx_clk_en), 16'h0001);
		@(posedge sys_clk) loopback_control <= 0;
		rwr(16'hDD72, 16'hDD72);
		check(16'(pcs_bypass_en), 16'h0001);
		check(16'(rx_clk_en), 16'h0001);
		rwr(16'h0000, 16'h0140);
		check(16'(mode_bits), 16'h0000);
		@(posedge sys_clk) mode_10m <= 1;
		mode_100tx <= 0;
		rx_pol_reversed <= 1;
		rd(5'h10, 16'h0150);
		check(16'(rx_invert), 16'h0001);
		check(16'(phy_irq), 16'h0001);
		@(posedge sys_clk) phy_event <= 1;
		repeat (2) @(posedge sys_clk);
		#1 check(16'(phy_irq), 16'h0000);
		rwr(16'h0160, 16'h0160);
		check(16'(rx_invert), 16'h0000);
		end_sim;
	end
	initial begin
		#20000;
		mismatches++;
		end_sim;
	end
endmodule : phy_vendor_mode_control_test
`default_nettype wire
